/* File: design/gpa_defines.vh */
// register offsets, field positions and reset values of the gpio port
`ifndef GPA_DEFINES_VH
`define GPA_DEFINES_VH
`define GPA_OFF_PIN      12'h000
`define GPA_OFF_DIR      12'h004
`define GPA_OFF_LAT      12'h008
`define GPA_OFF_CHGEN    12'h00C
`define GPA_OFF_PULLUP   12'h010
`define GPA_OFF_CTRL     12'h014
`define GPA_OFF_STATUS   12'h018
`define GPA_OFF_ANALOG   12'h01C
`define GPA_PIN_MASK     8'h3B
`define GPA_DIR_MASK     8'h30
`define GPA_PU_MASK      8'h3B
`define GPA_DIR_RST      8'h30
`define GPA_PU_RST       8'h3B
`define GPA_CHGEN_RST    8'h00
`define GPA_LAT_RST      8'h00
`define GPA_CTRL_IE      0
`define GPA_CTRL_PUDIS   1
`define GPA_CTRL_USB     2
`define GPA_STAT_FLAG    0
`define GPA_STAT_WAKE    1
`define GPA_ANA_CH3      3
`endif

/* File: design/gpa_port.v */
// five pin gpio port with change detection behind an apb slave
`timescale 1ns/100ps
//
// Notes on behaviour
// - direction bit 1 turns the pin driver off, pin is an input.
// - direction bit 0 drives the pin from its output latch bit.
// - pin register reads live levels; writes go to the output latch.
// - latch register reads the latched values, not pin levels.
// - pins 5,4 bidirectional; 3,1,0 input only; bits 7,6,2 read zero.
// - each pin has a change detect enable bit.
// - global change enable gates the change interrupt of all pins.
// - output pins never take part in change comparison.
// - enabled pins compared with last read value; mismatches ORed to flag.
// - a pending change interrupt raises the wake request.
// - port access reloads last read latch except file-to-file moves.
// - a lasting mismatch keeps setting the flag over software clears.
// - last read latch survives master clear and brown-out resets.
// - a change during the reading access may be missed.
// - usb ownership disables change detection on pins 0 and 1.
// - pins 1,0 digital input needs both enables set and usb off.
// - pull-up on needs its enable bit set and global disable clear.
// - pull-up off while pin is output; pull-ups off at power-on.
// - pin 3 reads as input only when master clear select is 0.
// - oscillator on pins 4,5 makes port, latch read zero; direction too unless crystal mode.
// - analog channel 3 select makes pin 4 read zero; set at power-on.
// - direction bits 5,4 read 1 in crystal modes; reset to 1.
// - latch register holds bits 5 and 4 only, others read zero.
`include "gpa_defines.vh"
module gpa_port #(
  parameter ADDR_W = 12
) (
  input  wire              pclk,
  input  wire              presetn,
  input  wire              por_n,
  input  wire              psel,
  input  wire              penable,
  input  wire              pwrite,
  input  wire [ADDR_W-1:0] paddr,
  input  wire [31:0]       pwdata,
  input  wire              move_ff,
  output reg  [31:0]       prdata,
  output reg               pready,
  output reg               pslverr,
  input  wire [7:0]        pin_in,
  output reg  [7:0]        pin_out,
  output reg  [7:0]        pin_oe_n,
  output reg  [7:0]        pullup_on,
  input  wire              master_clear_select,
  input  wire              osc_on_pins,
  input  wire              crystal_mode,
  output reg               change_irq,
  output reg               wake_req
);

  reg [7:0] sync1;
  reg [7:0] sync2;
  reg [7:0] dir;
  reg [7:0] lat;
  reg [7:0] chg_en;
  reg [7:0] pu_en;
  reg [7:0] last_read;
  reg       irq_en;
  reg       pu_gdis;
  reg       usb_en;
  reg       flag;
  reg       ana_ch3;
  reg [31:0] next_prdata;
  reg       next_slverr;
  reg       next_flag;
  reg       next_irq;
  reg [7:0] next_pin_out;
  reg [7:0] next_pin_oe_n;
  reg [7:0] next_pullup_on;

  // read data is registered in the setup cycle; writes and the
  // last-read reload wait for the access edge where pready stands high
  wire        setup = psel & ~penable;
  wire        done  = psel & penable & pready;
  wire        wr    = done & pwrite;
  wire        rd    = setup & ~pwrite;
  wire [11:0] a     = paddr[11:0];

  // offset compare shared by every write strobe
  function hit;
    input [11:0] addr;
    input [11:0] off;
    begin
      hit = (addr == off);
    end
  endfunction

  // decoded writes, one strobe per register
  wire        wr_pin    = wr & hit(a, `GPA_OFF_PIN);
  wire        wr_dir    = wr & hit(a, `GPA_OFF_DIR);
  wire        wr_lat    = wr & hit(a, `GPA_OFF_LAT);
  wire        wr_chgen  = wr & hit(a, `GPA_OFF_CHGEN);
  wire        wr_pullup = wr & hit(a, `GPA_OFF_PULLUP);
  wire        wr_ctrl   = wr & hit(a, `GPA_OFF_CTRL);
  wire        wr_status = wr & hit(a, `GPA_OFF_STATUS);
  wire        wr_analog = wr & hit(a, `GPA_OFF_ANALOG);
  // a move-instruction access leaves the mismatch standing
  wire        port_acc  = done & hit(a, `GPA_OFF_PIN) & ~move_ff;
  wire        flag_clr  = wr_status & pwdata[`GPA_STAT_FLAG];

  function [7:0] sel_bits;
    input [7:0] v;
    input [7:0] m;
    begin
      sel_bits = v & m;
    end
  endfunction

  // which pins deliver a digital level at the pin register
  wire       dig10 = (chg_en[1:0] == 2'b11) & ~usb_en;
  wire       dig3  = ~master_clear_select;
  wire       dig4  = ~osc_on_pins & ~ana_ch3;
  wire       dig5  = ~osc_on_pins;
  wire [7:0] dig_ok = {2'b00, dig5, dig4, dig3, 1'b0, dig10, dig10};
  wire [7:0] pin_view = sel_bits(sync2 & dig_ok, `GPA_PIN_MASK);
  wire [7:0] dir_view = crystal_mode ? `GPA_DIR_MASK :
                        (osc_on_pins ? 8'h00 : sel_bits(dir, `GPA_DIR_MASK));
  wire [7:0] lat_view = osc_on_pins ? 8'h00 :
                        sel_bits(lat, `GPA_DIR_MASK);
  // input pins only; usb strips pins 0 and 1
  wire [7:0] is_input = ~sel_bits(~dir, `GPA_DIR_MASK);
  wire [7:0] usb_cut = usb_en ? 8'hFC : 8'hFF;
  wire [7:0] cmp_en = chg_en & is_input & usb_cut & `GPA_PIN_MASK;
  // per-pin mismatch kept as a vector so each pin can be traced
  wire [7:0] diff     = (sync2 ^ last_read) & cmp_en;
  wire       mismatch = |diff;

  // first stage may go metastable; only the second stage is read
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1 <= 8'h00;
    end else begin
      sync1 <= pin_in;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync2 <= 8'h00;
    end else begin
      sync2 <= sync1;
    end
  end

  // last read latch only clears at power-on, so master clear leaves it
  always @(posedge pclk or negedge por_n) begin
    if (!por_n) begin
      last_read <= 8'h00;
    end else if (port_acc) begin
      last_read <= sync2;
    end
  end

  // pull-up enables load 0x3B at power-on only; master clear keeps them
  always @(posedge pclk or negedge por_n) begin
    if (!por_n) begin
      pu_en <= `GPA_PU_RST;
    end else if (wr_pullup) begin
      pu_en <= sel_bits(pwdata[7:0], `GPA_PU_MASK);
    end
  end

  // pull-ups stay off after power-on until software enables them
  always @(posedge pclk or negedge por_n) begin
    if (!por_n) begin
      pu_gdis <= 1'b1;
    end else if (wr_ctrl) begin
      pu_gdis <= pwdata[`GPA_CTRL_PUDIS];
    end
  end

  // pin 4 starts analog, so it reads zero until software frees it
  always @(posedge pclk or negedge por_n) begin
    if (!por_n) begin
      ana_ch3 <= 1'b1;
    end else if (wr_analog) begin
      ana_ch3 <= pwdata[`GPA_ANA_CH3];
    end
  end

  // direction reset leaves both bidirectional pins as inputs
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dir <= `GPA_DIR_RST;
    end else if (wr_dir) begin
      dir <= sel_bits(pwdata[7:0], `GPA_DIR_MASK);
    end
  end

  // the pin register write lands in the latch, never on the pin
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lat <= `GPA_LAT_RST;
    end else if (wr_pin | wr_lat) begin
      lat <= sel_bits(pwdata[7:0], `GPA_DIR_MASK);
    end
  end

  // bit 3 stays writable so pin 3 can wake the core
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chg_en <= `GPA_CHGEN_RST;
    end else if (wr_chgen) begin
      chg_en <= sel_bits(pwdata[7:0], `GPA_PIN_MASK);
    end
  end

  // interrupt enable and usb ownership share the control word
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_en <= 1'b0;
    end else if (wr_ctrl) begin
      irq_en <= pwdata[`GPA_CTRL_IE];
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      usb_en <= 1'b0;
    end else if (wr_ctrl) begin
      usb_en <= pwdata[`GPA_CTRL_USB];
    end
  end

  // a standing mismatch sets the flag again, so set wins over clear
  always @* begin
    next_flag = flag;
    if (mismatch)
      next_flag = 1'b1;
    else if (flag_clr)
      next_flag = 1'b0;
  end

  // flag follows presetn, last_read does not, so a mismatch re-arms it
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag <= 1'b0;
    end else begin
      flag <= next_flag;
    end
  end

  // output controls computed one step ahead of their flip-flops
  always @* begin
    next_pin_out   = sel_bits(lat, `GPA_DIR_MASK);
    next_pin_oe_n  = is_input | ~`GPA_DIR_MASK;
    if (osc_on_pins)
      next_pin_oe_n = 8'hFF;
    next_pullup_on = pu_gdis ? 8'h00 : (pu_en & is_input);
    next_irq       = flag & irq_en;
  end

  // control and status words as software sees them
  wire [7:0] ctrl_view   = {5'b00000, usb_en, pu_gdis, irq_en};
  wire [7:0] status_view = {6'b000000, wake_req, flag};
  wire [7:0] analog_view = {4'h0, ana_ch3, 3'b000};

  always @* begin
    next_prdata = 32'h0000_0000;
    next_slverr = 1'b0;
    case (a)
      `GPA_OFF_PIN: begin
        next_prdata[7:0] = pin_view;
      end
      `GPA_OFF_DIR: begin
        next_prdata[7:0] = dir_view;
      end
      `GPA_OFF_LAT: begin
        next_prdata[7:0] = lat_view;
      end
      `GPA_OFF_CHGEN: begin
        next_prdata[7:0] = chg_en;
      end
      `GPA_OFF_PULLUP: begin
        next_prdata[7:0] = pu_en;
      end
      `GPA_OFF_CTRL: begin
        next_prdata[7:0] = ctrl_view;
      end
      `GPA_OFF_STATUS: begin
        next_prdata[7:0] = status_view;
      end
      `GPA_OFF_ANALOG: begin
        next_prdata[7:0] = analog_view;
      end
      default: begin
        next_slverr = 1'b1;
      end
    endcase
  end

  // prdata holds until the next read, so a late sampler still sees it
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (rd) begin
      prdata <= next_prdata;
    end
  end

  // zero wait states: the answer stands in the access cycle only
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
    end else begin
      pready <= setup;
    end
  end

  // unmapped offsets answer with an error and read zero
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr <= 1'b0;
    end else begin
      pslverr <= setup & next_slverr;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_out <= 8'h00;
    end else begin
      pin_out <= next_pin_out;
    end
  end

  // oscillator pins are never driven from the latch
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_oe_n <= 8'hFF;
    end else begin
      pin_oe_n <= next_pin_oe_n;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pullup_on <= 8'h00;
    end else begin
      pullup_on <= next_pullup_on;
    end
  end

  // interrupt line is registered so it never glitches on the pins
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      change_irq <= 1'b0;
    end else begin
      change_irq <= next_irq;
    end
  end

  // wake request mirrors the pending interrupt so sleep can end
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wake_req <= 1'b0;
    end else begin
      wake_req <= next_irq;
    end
  end

endmodule

/* File: tb/gpa_monitor.sv */
// assertions on the gpio port apb answers and pin controls
`timescale 1ns/100ps
module gpa_monitor #(
  parameter ADDR_W = 12
) (
  input wire              pclk,
  input wire              presetn,
  input wire              psel,
  input wire              penable,
  input wire              pwrite,
  input wire [ADDR_W-1:0] paddr,
  input wire [31:0]       prdata,
  input wire              pready,
  input wire              osc_on_pins,
  input wire [7:0]        pin_oe_n,
  input wire [7:0]        pullup_on,
  input wire              change_irq,
  input wire              wake_req
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_oe_only_54: assert property ((pin_oe_n | 8'h30) == 8'hFF)
    else $error("input-only pin driven");
  a_pull_off_out: assert property (
    (pullup_on & (~pin_oe_n | 8'hC4)) == 8'h00)
    else $error("pull-up on a driven or absent pin");
  a_wake_follows: assert property (wake_req == change_irq)
    else $error("wake request differs from change interrupt");
  a_ready_setup: assert property (psel && !penable |=> pready)
    else $error("no answer in access cycle");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  a_pin_rd_mask: assert property (pready && !pwrite && paddr == 12'h000
    |-> (prdata & 32'hFFFFFFC4) == 32'h0)
    else $error("unimplemented pin bit reads nonzero");
  a_lat_rd_mask: assert property (pready && !pwrite && paddr == 12'h008
    |-> (prdata & 32'hFFFFFFCF) == 32'h0)
    else $error("latch bit outside 5:4 reads nonzero");
  a_oe_osc_off: assert property (osc_on_pins |=> pin_oe_n == 8'hFF)
    else $error("oscillator pin driven from the latch");
endmodule
bind gpa_port gpa_monitor #(.ADDR_W(ADDR_W)) u_mon (.pclk, .presetn, .psel,
  .penable, .pwrite, .paddr, .prdata, .pready, .osc_on_pins, .pin_oe_n,
  .pullup_on, .change_irq, .wake_req);

/* File: tb/gpa_pins.sv */
// board side of the port: drivers, pull-ups and floating lines
`timescale 1ns/100ps
module gpa_pins (
  input  wire       pclk,
  input  wire [7:0] pin_out,
  input  wire [7:0] pin_oe_n,
  input  wire [7:0] pullup_on,
  input  wire [7:0] ext_lvl,
  input  wire [7:0] ext_en,
  output wire [7:0] pin_in
);
  // an undriven line without pull-up must not settle to a friendly value
  reg [7:0] flt = 8'h00;
  always @(posedge pclk) begin
    flt <= ~flt;
  end
  assign pin_in = (~pin_oe_n & pin_out) | (pin_oe_n & ext_en & ext_lvl)
    | (pin_oe_n & ~ext_en & (pullup_on | flt));
endmodule

/* File: tb/gpa_port_tb_top.sv */
// apb test sequences for the gpio port with change detection
`timescale 1ns/100ps
module gpa_port_tb_top;
  reg         pclk = 1'h0;
  reg         presetn = 1'h0;
  reg         por_n = 1'h0;
  reg         psel = 1'h0;
  reg         penable = 1'h0;
  reg         pwrite = 1'h0;
  reg  [11:0] paddr = 12'h000;
  reg  [31:0] pwdata = 32'h0;
  reg         move_ff = 1'h0;
  reg  [2:0]  cfg = 3'h0;
  reg  [7:0]  ext_lvl = 8'h3B;
  reg  [7:0]  ext_en = 8'hFF;
  reg  [7:0]  rdat;
  reg         err;
  wire [31:0] prdata;
  wire [7:0]  pin_in, pin_out, pin_oe_n, pullup_on;
  wire        pready, pslverr, change_irq, wake_req;
  integer     fail_count = 0;
  integer     total_checks = 0;
  always #4 pclk = ~pclk;
  gpa_port #(.ADDR_W(12)) DUT (.pclk, .presetn, .por_n, .psel, .penable,
    .pwrite, .paddr, .pwdata, .move_ff, .prdata, .pready, .pslverr, .pin_in,
    .pin_out, .pin_oe_n, .pullup_on, .master_clear_select(cfg[2]),
    .osc_on_pins(cfg[1]), .crystal_mode(cfg[0]), .change_irq, .wake_req);
  gpa_pins u_pins (.pclk, .pin_out, .pin_oe_n, .pullup_on, .ext_lvl,
    .ext_en, .pin_in);
  task chk(input [7:0] got, input [7:0] exp);
    begin
      total_checks = total_checks + 1;
      if (got !== exp) begin
        fail_count = fail_count + 1;
        $display("wrong value at %0t: got %h want %h", $time, got, exp);
      end
    end
  endtask
  task xfer(input [11:0] a, input w, input [7:0] d);
    begin
      @(posedge pclk);
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h0, d};
      @(posedge pclk);
      penable <= 1'h1;
      @(posedge pclk);
      while (pready !== 1'h1) @(posedge pclk);
      rdat = prdata[7:0];
      err = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
    end
  endtask
  task rd(input [11:0] a, input [7:0] e);
    begin
      xfer(a, 1'h0, 8'h00);
      chk(rdat, e);
    end
  endtask
  // synchroniser plus flag stage settle well inside six cycles
  task pins(input [7:0] v);
    begin
      @(posedge pclk);
      ext_lvl <= v;
      repeat (6) @(posedge pclk);
    end
  endtask
  task irq(input e);
    begin
      @(posedge pclk);
      @(negedge pclk);
      chk({7'h0, change_irq}, {7'h0, e});
    end
  endtask
  task end_sim;
    begin
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0)
        $display("RESULT: PASS");
      else
        $display("RESULT: FAIL");
      $finish;
    end
  endtask
  initial begin
    #200000;
    fail_count = fail_count + 1;
    end_sim;
  end
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'h1;
    por_n <= 1'h1;
    rd(12'h004, 8'h30);
    rd(12'h014, 8'h02);
    rd(12'h01C, 8'h08);
    rd(12'h000, 8'h28);
    xfer(12'h00C, 1'h1, 8'h3B);
    xfer(12'h01C, 1'h1, 8'h00);
    xfer(12'h014, 1'h1, 8'h01);
    rd(12'h000, 8'h3B);
    xfer(12'h018, 1'h1, 8'h01);
    irq(1'h0);
    pins(8'h3A);
    irq(1'h1);
    xfer(12'h018, 1'h1, 8'h01);
    irq(1'h1);
    @(posedge pclk);
    move_ff <= 1'h1;
    xfer(12'h000, 1'h0, 8'h00);
    move_ff <= 1'h0;
    xfer(12'h018, 1'h1, 8'h01);
    irq(1'h1);
    rd(12'h000, 8'h3A);
    xfer(12'h018, 1'h1, 8'h01);
    irq(1'h0);
    @(posedge pclk);
    presetn <= 1'h0;
    @(posedge pclk);
    presetn <= 1'h1;
    xfer(12'h00C, 1'h1, 8'h3B);
    xfer(12'h014, 1'h1, 8'h01);
    irq(1'h0);
    xfer(12'h014, 1'h1, 8'h05);
    pins(8'h3B);
    irq(1'h0);
    rd(12'h000, 8'h38);
    xfer(12'h004, 1'h1, 8'h00);
    xfer(12'h000, 1'h1, 8'h10);
    rd(12'h008, 8'h10);
    chk(pin_out, 8'h10);
    chk(pin_oe_n, 8'hCF);
    chk(pullup_on, 8'h0B);
    ext_en <= 8'hF7;
    pins(8'h33);
    rd(12'h000, 8'h18);
    cfg <= 3'h2;
    rd(12'h004, 8'h00);
    rd(12'h008, 8'h00);
    cfg <= 3'h1;
    rd(12'h004, 8'h30);
    cfg <= 3'h4;
    pins(8'h3B);
    rd(12'h000, 8'h10);
    rd(12'h020, 8'h00);
    chk({7'h0, err}, 8'h01);
    end_sim;
  end
endmodule
